// *** core/hdt_link_tx.sv ***
// hdlc facility data link transmitter with apb register access
`timescale 1ns/1ps

module hdt_link_tx #(
  parameter int BIT_DIV = hdt_pkg::BIT_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [hdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           tx_link_data,
  output logic                           tx_link_irq_out,
  output logic                           host_irq_pin
);

  // elaboration check on the bit divider
  if (BIT_DIV < 2 || BIT_DIV > (1 << hdt_pkg::DIV_W))
  begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  localparam logic [hdt_pkg::DIV_W-1:0] DIV_LAST =
    hdt_pkg::DIV_W'(BIT_DIV - 1);

  hdt_pkg::hdt_regs_t s_ff;
  hdt_pkg::hdt_regs_t nxt_s;

  // register decode, used for read mux and write strobes
  function automatic logic is_reg(input logic [hdt_pkg::ADDR_W-1:0] a,
                                  input logic [9:0] idx);
    is_reg = (a[hdt_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // bit order swap so the fcs high bit leaves first
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
    begin
      rev16[i] = v[15-i];
    end
  endfunction

  // outputs straight from the state record
  assign prdata          = {24'h000000, s_ff.prdata};
  assign pready          = s_ff.pready;
  assign pslverr         = s_ff.pslverr;
  assign tx_link_data    = s_ff.txd;
  assign tx_link_irq_out = s_ff.irq;
  assign host_irq_pin    = s_ff.hirq;

  // next state: bus slave, bit engine, symbol sequencer
  always_comb
  begin
    logic       acc;
    logic       done;
    logic       wr;
    logic       hit_cfg;
    logic       hit_sts;
    logic       hit_dat;
    logic       hit_opt;
    logic       tick;
    logic       b;
    logic       fb;
    logic       boundary;
    logic       start_data;
    logic [7:0] rd;
    nxt_s      = s_ff;
    acc        = psel & penable;
    done       = acc & s_ff.pready;
    wr         = done & pwrite;
    hit_cfg    = is_reg(paddr, hdt_pkg::IDX_CONFIG);
    hit_sts    = is_reg(paddr, hdt_pkg::IDX_STATUS);
    hit_dat    = is_reg(paddr, hdt_pkg::IDX_DATA);
    hit_opt    = is_reg(paddr, hdt_pkg::IDX_OPTIONS);
    tick       = (s_ff.div == DIV_LAST);
    b          = 1'b1;
    fb         = 1'b0;
    boundary   = 1'b0;
    start_data = 1'b0;
    rd         = 8'h00;

    // apb: one wait state, answer registered
    nxt_s.pready = acc & ~s_ff.pready;
    if (hit_cfg)
    begin
      rd[hdt_pkg::BIT_EOP]  = s_ff.eop;
      rd[hdt_pkg::BIT_IRQ_OUT_ENABLE] = s_ff.irq_out_enable;
      rd[hdt_pkg::BIT_ABT]  = s_ff.abort_request;
      rd[hdt_pkg::BIT_CRC]  = s_ff.crc_en;
      rd[hdt_pkg::BIT_EN]   = s_ff.en;
    end
    else if (hit_sts)
    begin
      rd[hdt_pkg::BIT_INT] = ~s_ff.hold_full;
      rd[hdt_pkg::BIT_UDR] = s_ff.underrun_flag;
    end
    else if (hit_dat)
    begin
      rd = s_ff.hold_data;
    end
    else if (hit_opt)
    begin
      rd[hdt_pkg::BIT_ROUTE] = s_ff.route;
    end
    if (acc & ~s_ff.pready)
    begin
      nxt_s.prdata  = pwrite ? 8'h00 : rd;
      nxt_s.pslverr = ~(hit_cfg | hit_sts | hit_dat | hit_opt);
    end
    else if (done)
    begin
      nxt_s.prdata  = 8'h00;
      nxt_s.pslverr = 1'b0;
    end

    // underrun flag: only a written zero clears it
    if (wr && hit_sts && !pwdata[hdt_pkg::BIT_UDR])
    begin
      nxt_s.underrun_flag = 1'b0;
    end

    // bit period divider
    nxt_s.div = tick ? '0 : s_ff.div + 1'b1;

    if (!s_ff.en)
    begin
      // disabled: line idles high, sequencer parked
      nxt_s.st   = hdt_pkg::ST_OFF;
      nxt_s.txd  = 1'b1;
      nxt_s.cnt  = 5'h00;
      nxt_s.ones = 3'h0;
    end
    else if (tick)
    begin
      if (s_ff.st == hdt_pkg::ST_OFF)
      begin
        nxt_s.txd = 1'b1;
        boundary  = 1'b1;
      end
      else if (s_ff.ones == hdt_pkg::STUFF_RUN)
      begin
        // transparency zero, nothing shifted
        nxt_s.txd  = 1'b0;
        nxt_s.ones = 3'h0;
      end
      else
      begin
        b         = s_ff.sh[0];  // lsb leaves first
        nxt_s.txd = b;
        nxt_s.sh  = {1'b0, s_ff.sh[15:1]};
        nxt_s.cnt = s_ff.cnt - 5'h01;
        if (s_ff.st == hdt_pkg::ST_DATA || s_ff.st == hdt_pkg::ST_FCS)
        begin
          nxt_s.ones = b ? s_ff.ones + 3'h1 : 3'h0;
        end
        else
        begin
          nxt_s.ones = 3'h0;  // no stuffing in flags or aborts
        end
        if (s_ff.st == hdt_pkg::ST_DATA)
        begin
          // crc over data bits in line order
          fb        = s_ff.crc[15] ^ b;
          nxt_s.crc = {s_ff.crc[14:0], 1'b0} ^
                      (fb ? hdt_pkg::CRC_POLY : 16'h0000);
        end
        boundary = (s_ff.cnt == 5'h01);
      end
    end

    // symbol sequencer at each octet end
    if (boundary)
    begin
      nxt_s.st  = hdt_pkg::ST_FLAG;  // default: idle flags
      nxt_s.sh  = {8'h00, hdt_pkg::FLAG_CODE};
      nxt_s.cnt = hdt_pkg::OCTET_LEN;
      case (s_ff.st)
        hdt_pkg::ST_DATA:
        begin
          if (s_ff.abort_request)
          begin
            nxt_s.st = hdt_pkg::ST_ABORT;
          end
          else if (s_ff.eop && !s_ff.hold_full)
          begin
            nxt_s.eop = 1'b0;
            if (s_ff.crc_en)
            begin
              // complemented crc, high bit first
              nxt_s.st  = hdt_pkg::ST_FCS;
              nxt_s.sh  = rev16(~nxt_s.crc);
              nxt_s.cnt = hdt_pkg::FCS_LEN;
            end
          end
          else if (s_ff.hold_full)
          begin
            start_data = 1'b1;
          end
          else
          begin
            nxt_s.underrun_flag = 1'b1;
            nxt_s.st  = hdt_pkg::ST_UABORT;
          end
        end
        hdt_pkg::ST_FCS:
        begin
          nxt_s.st = hdt_pkg::ST_FLAG;
        end
        hdt_pkg::ST_UABORT:
        begin
          nxt_s.st = hdt_pkg::ST_UFLAG;  // one flag after abort
        end
        hdt_pkg::ST_UFLAG,
        hdt_pkg::ST_MARK:
        begin
          if (s_ff.underrun_flag)
          begin
            nxt_s.st = hdt_pkg::ST_MARK;  // all-ones idle
          end
          else if (s_ff.abort_request)
          begin
            nxt_s.st = hdt_pkg::ST_ABORT;
          end
          else
          begin
            start_data = s_ff.hold_full;
          end
        end
        hdt_pkg::ST_OFF,
        hdt_pkg::ST_FLAG,
        hdt_pkg::ST_ABORT:
        begin
          if (s_ff.abort_request)
          begin
            nxt_s.st = hdt_pkg::ST_ABORT;  // repeat while set
          end
          else
          begin
            start_data = s_ff.hold_full && s_ff.st != hdt_pkg::ST_OFF;
          end
        end
        default:
        begin
          nxt_s.st = hdt_pkg::ST_FLAG;
        end
      endcase
      if (nxt_s.st == hdt_pkg::ST_ABORT)
      begin
        nxt_s.sh = {8'h00, hdt_pkg::ABORT_CODE};
      end
      else if (nxt_s.st == hdt_pkg::ST_UABORT)
      begin
        nxt_s.sh = {8'h00, hdt_pkg::ABORT_CODE};
      end
      else if (nxt_s.st == hdt_pkg::ST_MARK)
      begin
        nxt_s.sh = {8'h00, hdt_pkg::MARK_CODE};
      end
      if (start_data)
      begin
        // held byte moves to the shifter, request raised
        if (s_ff.st != hdt_pkg::ST_DATA)
        begin
          nxt_s.crc = hdt_pkg::CRC_INIT;
        end
        nxt_s.st        = hdt_pkg::ST_DATA;
        nxt_s.sh        = {8'h00, s_ff.hold_data};
        nxt_s.hold_full = 1'b0;
      end
    end

    // register writes after the engine so a fresh byte or setting wins
    if (wr && hit_cfg)
    begin
      nxt_s.eop    = pwdata[hdt_pkg::BIT_EOP];
      nxt_s.irq_out_enable   = pwdata[hdt_pkg::BIT_IRQ_OUT_ENABLE];
      nxt_s.abort_request    = pwdata[hdt_pkg::BIT_ABT];
      nxt_s.crc_en = pwdata[hdt_pkg::BIT_CRC];
      nxt_s.en     = pwdata[hdt_pkg::BIT_EN];
    end
    if (wr && hit_dat)
    begin
      nxt_s.hold_data = pwdata[7:0];
      nxt_s.hold_full = 1'b1;  // request withdrawn while byte waits
    end
    if (wr && hit_opt)
    begin
      nxt_s.route = pwdata[hdt_pkg::BIT_ROUTE];
    end

    // byte request onto the interrupt outputs
    nxt_s.irq  = nxt_s.en & nxt_s.irq_out_enable & ~nxt_s.hold_full;
    nxt_s.hirq = nxt_s.irq & nxt_s.route;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff           <= '0;
      s_ff.st        <= hdt_pkg::ST_OFF;
      s_ff.txd       <= 1'b1;
      s_ff.crc       <= hdt_pkg::CRC_INIT;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

endmodule // hdt_link_tx

// *** core/hdt_pkg.sv ***
// shared constants, state codes and the state record of the link transmitter
package hdt_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONFIG  = 10'h034;
  localparam logic [9:0] IDX_STATUS  = 10'h035;
  localparam logic [9:0] IDX_DATA    = 10'h036;
  localparam logic [9:0] IDX_OPTIONS = 10'h037;
  localparam int         ADDR_W      = 12;

  // configuration register fields
  localparam int BIT_EOP   = 4;
  localparam int BIT_IRQ_OUT_ENABLE  = 3;
  localparam int BIT_ABT   = 2;
  localparam int BIT_CRC   = 1;
  localparam int BIT_EN    = 0;
  // status register fields
  localparam int BIT_INT   = 1;
  localparam int BIT_UDR   = 0;
  // options register field
  localparam int BIT_ROUTE = 0;

  // line codes, sent least significant bit first
  localparam logic [7:0]  FLAG_CODE  = 8'h7e;
  localparam logic [7:0]  ABORT_CODE = 8'h7f;
  localparam logic [7:0]  MARK_CODE  = 8'hff;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_INIT   = 16'hffff;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [4:0]  OCTET_LEN  = 5'h08;
  localparam logic [4:0]  FCS_LEN    = 5'h10;

  // bit period: clock rate and data link bit rate
  localparam int CLK_HZ      = 10000000;
  localparam int LINK_BPS    = 4000;
  localparam int BIT_CYCLES  = CLK_HZ / LINK_BPS;
  localparam int DIV_W       = 16;

  // transmitter states, one-hot
  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_FLAG   = 8'h02,
    ST_DATA   = 8'h04,
    ST_FCS    = 8'h08,
    ST_ABORT  = 8'h10,
    ST_UABORT = 8'h20,
    ST_UFLAG  = 8'h40,
    ST_MARK   = 8'h80
  } hdt_state_t;

  // whole state of the transmitter
  typedef struct packed {
    hdt_state_t        st;
    logic              eop;
    logic              irq_out_enable;
    logic              abort_request;
    logic              crc_en;
    logic              en;
    logic              route;
    logic              underrun_flag;
    logic              hold_full;
    logic [7:0]        hold_data;
    logic [15:0]       sh;
    logic [4:0]        cnt;
    logic [2:0]        ones;
    logic [15:0]       crc;
    logic [DIV_W-1:0]  div;
    logic              pready;
    logic              pslverr;
    logic [7:0]        prdata;
    logic              txd;
    logic              irq;
    logic              hirq;
  } hdt_regs_t;

endpackage

// *** verif/hdt_link_tx_checker.sv ***
// port assertions for the link transmitter
`timescale 1ns/1ps
module hdt_link_tx_checker #(
  parameter int BIT_DIV = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_link_data,
  input wire logic        tx_link_irq_out,
  input wire logic        host_irq_pin
);
  logic [7:0] cfg_ff;
  logic       rte_ff;
  logic       udr_ff;
  logic       acc;

  // an accepted transfer
  assign acc = psel && penable && pready && !pslverr;

  // shadow of written enables and of a seen underrun
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff <= 8'h00;
      rte_ff <= 1'b0;
      udr_ff <= 1'b0;
    end
    else if (acc)
    begin
      if (pwrite && paddr == 12'h0d0)
        cfg_ff <= pwdata[7:0];
      if (pwrite && paddr == 12'h0dc)
        rte_ff <= pwdata[0];
      if (paddr == 12'h0d4)
        udr_ff <= pwrite ? udr_ff && pwdata[0] : prdata[0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence

  property p_apb_wait; s_setup ##1 s_wait |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("late ready");
  property p_slverr;
    pready && !(paddr inside {12'h0d0, 12'h0d4, 12'h0d8, 12'h0dc})
      |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no slave error");
  property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused data");
  property p_irq_gate; !cfg_ff[3] |-> !tx_link_irq_out; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
  property p_irq_dis; !cfg_ff[0] |-> !tx_link_irq_out; endproperty
  a_irq_dis: assert property (p_irq_dis) else $error("irq when off");
  property p_route_off; !rte_ff |-> !host_irq_pin; endproperty
  a_route_off: assert property (p_route_off) else $error("host irq");
  property p_line_idle; !cfg_ff[0] |=> tx_link_data; endproperty
  a_line_idle: assert property (p_line_idle) else $error("line busy");
  property p_udr_sticky;
    pready && !pwrite && paddr == 12'h0d4 && udr_ff |-> prdata[0];
  endproperty
  a_udr_sticky: assert property (p_udr_sticky) else $error("udr lost");
endmodule // hdt_link_tx_checker

// *** verif/hdt_link_rx_model.sv ***
// far-end line receiver: bit recovery, destuffing, framing
`timescale 1ns/1ps
module hdt_link_rx_model #(
  parameter int BIT_DIV = 8
) (
  input  wire logic       pclk,
  input  wire logic       line,
  output logic            byte_v,
  output logic [7:0]      byte_d,
  output int              n_flag,
  output int              n_abort,
  output int              ones
);
  int         cnt = 0;
  int         nb = 0;
  logic       prv = 1'b1;
  logic       fr = 1'b0;
  logic       stf;
  logic [7:0] win = 8'h00;
  logic [7:0] acc = 8'h00;

  // counters start clear
  initial
  begin
    n_flag = 0;
    n_abort = 0;
    ones = 0;
  end

  // resync on edges, sample mid bit, strip stuffing
  always @(posedge pclk)
  begin
    byte_v <= 1'b0;
    cnt = (line != prv || cnt == BIT_DIV - 1) ? 0 : cnt + 1;
    prv = line;
    if (cnt == BIT_DIV / 2)
    begin
      win = {win[6:0], line};
      stf = !line && ones == 5;
      ones = line ? ones + 1 : 0;
      if (ones >= 7)
        fr = 1'b0;
      if (win == 8'hfe)
        n_abort++;
      if (win == hdt_pkg::FLAG_CODE)
      begin
        fr = 1'b1;
        nb = 0;
        n_flag++;
      end
      else if (fr && !stf)
      begin
        acc = {line, acc[7:1]};
        nb++;
        if (nb == 8)
        begin
          byte_d <= acc;
          byte_v <= 1'b1;
          nb = 0;
        end
      end
    end
  end
endmodule // hdt_link_rx_model

// *** verif/tb_hdt_link_tx.sv ***
// self-checking bench for the link transmitter
`timescale 1ns/1ps
module tb_hdt_link_tx;
  localparam int BD = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, txd, irq, hirq, bv;
  logic [7:0]  bd, f;
  logic [8:0]  rq[$];
  logic [7:0]  lq[$];
  logic [15:0] rnd = 16'h0507;
  logic [15:0] crc;
  int          nf, na, n1, a0;
  int          error_cnt = 0;
  int          n_tests = 0;

  hdt_link_tx #(.BIT_DIV(BD)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_link_data(txd), .tx_link_irq_out(irq),
    .host_irq_pin(hirq));
  hdt_link_rx_model #(.BIT_DIV(BD)) mon_u (.pclk(pclk), .line(txd),
    .byte_v(bv), .byte_d(bd), .n_flag(nf), .n_abort(na), .ones(n1));

  always #50 pclk = ~pclk;

  task automatic chk(input logic [8:0] s, input logic [8:0] e,
                     input string nm);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [8:0] e);
    rq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask

  // next value of the stimulus lfsr
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? hdt_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction

  // write one random byte once a byte is requested
  task automatic send;
    for (int k = 0; k < 400 && irq !== 1'b1; k++)
      @(posedge pclk);
    rnd = lfsr(rnd);
    lq.push_back(rnd[7:0]);
    crc = crc8(crc, rnd[7:0]);
    wr(12'h0d8, rnd[7:0]);
    repeat (3) @(posedge pclk);
  endtask

  // compare read results and received bytes as they appear
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && !pwrite)
      chk({pslverr, prdata[7:0]}, rq.pop_front(), "read");
    if (bv === 1'b1)
      chk({1'b0, bd}, lq.pop_front(), "line byte");
  end

  initial
  begin
    #2000000;
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h0d0, 9'h000);
    rd(12'h0d4, 9'h002);
    rd(12'h0e0, 9'h100);
    wr(12'h0dc, 8'h01);
    wr(12'h0d0, 8'h0b);
    repeat (40 * BD) @(posedge pclk);
    chk({8'h0, irq}, 9'h001, "irq");
    chk({8'h0, hirq}, 9'h001, "host irq");
    chk({8'h0, nf > 2}, 9'h001, "flags");
    crc = hdt_pkg::CRC_INIT;
    repeat (3) send();
    wr(12'h0d0, 8'h1b);
    f = ~crc[15:8];
    lq.push_back({<<{f}});
    f = ~crc[7:0];
    lq.push_back({<<{f}});
    repeat (60 * BD) @(posedge pclk);
    chk({8'h0, lq.size() == 0}, 9'h001, "frame");
    rd(12'h0d0, 9'h00b);
    a0 = na;
    send();
    repeat (60 * BD) @(posedge pclk);
    rd(12'h0d4, 9'h003);
    chk({8'h0, na > a0}, 9'h001, "underrun abort");
    chk({8'h0, n1 > 16}, 9'h001, "idle ones");
    wr(12'h0d4, 8'h01);
    rd(12'h0d4, 9'h003);
    wr(12'h0d4, 8'h00);
    rd(12'h0d4, 9'h002);
    a0 = na;
    wr(12'h0d0, 8'h0f);
    repeat (40 * BD) @(posedge pclk);
    chk({8'h0, na > a0 + 2}, 9'h001, "aborts");
    wr(12'h0d0, 8'h03);
    repeat (4) @(posedge pclk);
    chk({8'h0, irq}, 9'h000, "gated irq");
    rd(12'h0d4, 9'h002);
    wr(12'h0dc, 8'h00);
    wr(12'h0d0, 8'h00);
    repeat (4 * BD) @(posedge pclk);
    chk({8'h0, txd}, 9'h001, "idle line");
    results();
  end
endmodule // tb_hdt_link_tx

bind hdt_link_tx hdt_link_tx_checker #(.BIT_DIV(BIT_DIV)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_link_data(tx_link_data),
  .tx_link_irq_out(tx_link_irq_out), .host_irq_pin(host_irq_pin));
